/* inc/sbe_defs.svh */
// Constants of the serial EEPROM bus front end: offsets, fields, reset values, timing.
`ifndef SBE_DEFS_SVH
`define SBE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses on the APB side)
// ----------------------------------------------------------------------------
`define SBE_REG_CTRL 12'h000
`define SBE_REG_STATUS 12'h004
`define SBE_REG_ADDR 12'h008
`define SBE_REG_DEVWORD 12'h00C
`define SBE_CTRL_EN_BIT 0
`define SBE_CTRL_RESET 1'b1
`define SBE_ST_STANDBY_BIT 0
`define SBE_ST_BUSY_BIT 1
`define SBE_ST_WP_BIT 2
`define SBE_ST_RW_BIT 3

// ----------------------------------------------------------------------------
// Protocol constants
// ----------------------------------------------------------------------------
`define SBE_PREFIX 4'hA
`define SBE_LAST_BIT 4'h7
`define SBE_BYTE_DONE 4'h8

// ----------------------------------------------------------------------------
// Capacity selection
// ----------------------------------------------------------------------------
`define SBE_CAP_2K 0
`define SBE_CAP_4K 1
`define SBE_CAP_8K 2
`define SBE_CAP_16K 3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SBE_TWR_NS 5000000
`define SBE_CLK_NS 4

`endif

/* inc/sbe_pkg.sv */
// Types shared by the serial EEPROM bus front end.
package sbe_pkg;

  // --------------------------------------------------------------------------
  // Link state machine and byte roles
  // --------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SBE_ST_IDLE = 3'b000,
    SBE_ST_RX = 3'b001,
    SBE_ST_ACK = 3'b010,
    SBE_ST_TX = 3'b011,
    SBE_ST_MACK = 3'b100,
    SBE_ST_PROG = 3'b101
  } sbe_state_t;

  typedef enum logic [1:0]
  {
    SBE_IDX_DEV = 2'b00,
    SBE_IDX_WADDR = 2'b01,
    SBE_IDX_DATA = 2'b10
  } sbe_idx_t;

endpackage

/* tb/sbe_front_end_sva.sv */
// Concurrent checks on the ports of the serial EEPROM front end.
`timescale 1ns/1ps

module sbe_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Link and status
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic standby_o,
  input wire logic busy_o
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // First access edge of an APB transfer, answer not yet given.
  sequence acc_wait_s;
    psel && penable && !pready && !$past(penable);
  endsequence

  // Data rising while the clock stays high is a stop on the wire.
  sequence stop_s;
    scl_i && $past(scl_i) && sda_i && !$past(sda_i);
  endsequence

  oe_drain_a:
    assert property (sda_oe |-> !sda_o) else $error("data line driven high");
  oe_still_a:
    assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
      else $error("data line moved while clock high");
  busy_quiet_a:
    assert property (busy_o |-> !sda_oe) else $error("answer during write cycle");
  busy_awake_a:
    assert property (busy_o |-> !standby_o) else $error("standby during write cycle");
  idle_mute_a:
    assert property (standby_o |-> !sda_oe) else $error("answer while in standby");
  stop_idle_a:
    assert property (stop_s |-> ##[1:12] (standby_o || busy_o))
      else $error("no standby after stop");
  ready_wait_a:
    assert property (acc_wait_s |=> pready) else $error("pready not after one wait");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
endmodule // sbe_chk

bind sbe_front_end sbe_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .standby_o(standby_o), .busy_o(busy_o));

/* tb/sbe_tb_master.sv */
// Behavioural two-wire bus master facing the front end.
`timescale 1ns/1ps

module sbe_tb_master (
  // Link pins; the data line is pulled up outside
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Quarter of the 160 ns link period.
  localparam int Q = 40;

  // Both lines idle high; the clock stands still between frames.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start: data falls with the clock high.
  // Pins move by non-blocking assignment so the core's sampling edge never races them.
  task automatic start();
    sda_low <= 1'b0;
    #Q scl <= 1'b1;
    #Q sda_low <= 1'b1;
    #Q scl <= 1'b0;
    #Q;
  endtask

  // Stop: data rises with the clock high, and the clock then stays high.
  task automatic stop();
    sda_low <= 1'b1;
    #Q scl <= 1'b1;
    #Q sda_low <= 1'b0;
    #Q;
  endtask

  // Data moves only in the clock-low phase.
  task automatic bit_out(input logic b);
    sda_low <= !b;
    #Q scl <= 1'b1;
    #(2*Q) scl <= 1'b0;
    #Q;
  endtask

  // Released line, sampled mid high phase.
  task automatic bit_in(output logic b);
    sda_low <= 1'b0;
    #Q scl <= 1'b1;
    #Q b = sda;
    #Q scl <= 1'b0;
    #Q;
  endtask

  // Eight bits first-most-significant, answer read on the ninth clock.
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask

  // Eight bits in, then our own answer; one means no acknowledge.
  task automatic byte_in(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask

  // Nine clocks with data released, then a start.
  task automatic recover();
    logic b;
    repeat (9) bit_in(b);
    start();
  endtask
endmodule // sbe_tb_master

/* tb/test_serial_eeprom_bus_front_end.sv */
// Self-checking bench of the front end in its 8K organisation.
`timescale 1ns/1ps
`include "sbe_defs.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end

module test_serial_eeprom_bus_front_end;
  // Short write cycle so that a polling word fits inside it.
  localparam int unsigned TWR = 600;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sda_o, sda_oe;
  logic scl, sda_low, wp_i, standby_o, busy_o, k, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] straps;
  logic [9:0] a;
  logic [7:0] d, q;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  wire sda;

  // Open-drain wire with its pull-up.
  assign sda = !((sda_oe && !sda_o) || sda_low);

  sbe_front_end #(.CAPACITY(`SBE_CAP_8K), .TWR_CYCLES(TWR)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_straps(straps),
    .wp_i(wp_i), .standby_o(standby_o), .busy_o(busy_o));
  sbe_tb_master i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));

  // 250 MHz clock.
  always #2 pclk = ~pclk;

  // Hang guard; the whole sequence needs about 44000 cycles.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // APB master: setup, access, hold until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the hang guard ends this wait.
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Device word of this part: prefix, top strap, page bits, direction.
  function automatic logic [7:0] dw(input logic [1:0] pg, input logic rd);
    return {`SBE_PREFIX, straps[2], pg, rd};
  endfunction

  // Answer expected in 8K: prefix and top strap only.
  function automatic logic hit(input logic [7:0] w);
    return w[7:4] == `SBE_PREFIX && w[3] == straps[2];
  endfunction

  // Byte write; with protect low a timed cycle runs and ignores polling.
  task automatic wr(input logic [9:0] ad, input logic [7:0] dt);
    logic k0, k1, k2;
    i_mst.start();
    i_mst.byte_out(dw(ad[9:8], 1'b0), k0);
    i_mst.byte_out(ad[7:0], k1);
    i_mst.byte_out(dt, k2);
    i_mst.stop();
    `CHK("write acks", 3'b111, {k0, k1, k2})
    repeat (12) @(posedge pclk);
    `CHK("busy", !wp_i, busy_o)
    if (busy_o === 1'b1)
    begin
      i_mst.start();
      i_mst.byte_out(dw(2'b00, 1'b0), k0);
      i_mst.stop();
      `CHK("poll ack", 1'b0, k0)
    end
    for (int n = 0; n < 1000 && busy_o !== 1'b0; n++) @(posedge pclk);
    `CHK("standby after write", 1'b1, standby_o)
  endtask

  // Random read: dummy write of the address, repeated start, one byte, no answer.
  task automatic rd(input logic [9:0] ad, output logic [7:0] dt);
    logic k0, k1, k2;
    i_mst.start();
    i_mst.byte_out(dw(ad[9:8], 1'b0), k0);
    i_mst.byte_out(ad[7:0], k1);
    i_mst.start();
    i_mst.byte_out(dw(2'b00, 1'b1), k2);
    i_mst.byte_in(1'b1, dt);
    i_mst.stop();
    `CHK("read acks", 3'b111, {k0, k1, k2})
    repeat (12) @(posedge pclk);
    `CHK("standby after read", 1'b1, standby_o)
  endtask

  // Main sequence.
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, wp_i} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    r = $urandom(32'h70A8);
    straps = 3'($urandom);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("reset standby", 1'b1, standby_o)
    `CHK("reset oe", 1'b0, sda_oe)
    apb(1'b0, `SBE_REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, r)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 1'b1, e)
    apb(1'b1, `SBE_REG_CTRL, 32'h0);
    i_mst.start();
    i_mst.byte_out(dw(2'b00, 1'b0), k);
    i_mst.stop();
    `CHK("disabled ack", 1'b0, k)
    apb(1'b1, `SBE_REG_CTRL, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 16; i++)
    begin
      d = {i[3] ? 4'hB : 4'hA, i[2:0], 1'b0};
      i_mst.start();
      i_mst.byte_out(d, k);
      i_mst.stop();
      `CHK("select ack", hit(d), k)
    end
    $display("test addressing done");
    for (int t = 0; t < 3; t++)
    begin
      a = (t == 0) ? 10'h3FF : 10'($urandom);
      d = 8'($urandom);
      wr(a, d);
      wr(a ^ 10'h300, ~d);
      rd(a, q);
      `CHK("data", d, q)
      rd(a ^ 10'h300, q);
      `CHK("other page", ~d, q)
      wp_i <= 1'b1;
      wr(a, d ^ 8'h5A);
      wp_i <= 1'b0;
      rd(a, q);
      `CHK("protected", d, q)
    end
    apb(1'b0, `SBE_REG_DEVWORD, 32'h0);
    `CHK("devword", {24'h0, dw(2'b00, 1'b1)}, r)
    // Three bytes from the second-last page slot wrap to the page start.
    a = {a[9:4], 4'hE};
    i_mst.start();
    i_mst.byte_out(dw(a[9:8], 1'b0), k);
    i_mst.byte_out(a[7:0], k);
    for (int i = 0; i < 3; i++)
      i_mst.byte_out(8'hC0 + 8'(i), k);
    i_mst.stop();
    repeat (TWR + 20) @(posedge pclk);
    // Sequential read: the master acknowledges the first byte and gets the next.
    i_mst.start();
    i_mst.byte_out(dw(a[9:8], 1'b0), k);
    i_mst.byte_out(a[7:0], k);
    i_mst.start();
    i_mst.byte_out(dw(2'b00, 1'b1), k);
    `CHK("sequential ack", 1'b1, k)
    i_mst.byte_in(1'b0, q);
    `CHK("sequential first", 8'hC0, q)
    i_mst.byte_in(1'b1, q);
    i_mst.stop();
    `CHK("sequential second", 8'hC1, q)
    rd({a[9:4], 4'h0}, q);
    `CHK("page wrap", 8'hC2, q)
    $display("test memory done");
    i_mst.start();
    repeat (4) i_mst.bit_out(1'b1);
    i_mst.start();
    i_mst.byte_out(dw(a[9:8], 1'b0), k);
    `CHK("restart ack", 1'b1, k)
    // A written location, so the interrupted read drives known bits.
    i_mst.byte_out(a[7:0], k);
    i_mst.start();
    i_mst.byte_out(dw(2'b00, 1'b1), k);
    repeat (3) i_mst.bit_in(k);
    i_mst.recover();
    i_mst.byte_out(dw(2'b00, 1'b0), k);
    i_mst.stop();
    `CHK("recovered ack", 1'b1, k)
    $display("test recovery done");
    summarize();
  end
endmodule // test_serial_eeprom_bus_front_end

/* verilog/sbe_front_end.sv */
// Target-side two-wire front end of a serial EEPROM with its array and an APB port.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "sbe_defs.svh"

module sbe_front_end #(
  parameter int CAPACITY = `SBE_CAP_16K,
  parameter int unsigned TWR_CYCLES = `SBE_TWR_NS / `SBE_CLK_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Two-wire link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and protect pin
  input wire logic [2:0] chip_select_straps,
  input wire logic wp_i,
  // Status
  output logic standby_o,
  output logic busy_o
);

  // --------------------------------------------------------------------------
  // Organisation helpers
  // --------------------------------------------------------------------------

  // Select bits compared with straps; the rest carry page address.
  function automatic logic [2:0] strap_mask(input int cap);
    logic [2:0] m;
    m = 3'b000;
    if (cap == `SBE_CAP_2K)
      m = 3'b111;
    else if (cap == `SBE_CAP_4K)
      m = 3'b110;
    else if (cap == `SBE_CAP_8K)
      m = 3'b100;
    return m;
  endfunction

  // Word address width per capacity.
  function automatic logic [10:0] addr_mask(input int cap);
    logic [10:0] m;
    m = 11'h7FF;
    if (cap == `SBE_CAP_2K)
      m = 11'h0FF;
    else if (cap == `SBE_CAP_4K)
      m = 11'h1FF;
    else if (cap == `SBE_CAP_8K)
      m = 11'h3FF;
    return m;
  endfunction

  // In-page offset bits: 8-byte pages on 2K, 16-byte pages elsewhere.
  function automatic logic [10:0] page_mask(input int cap);
    return (cap == `SBE_CAP_2K) ? 11'h007 : 11'h00F;
  endfunction

  // Prefix and strap compare on a received device address word.
  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] st,
                                     input int cap);
    return (b[7:4] == `SBE_PREFIX) && (((b[3:1] ^ st) & strap_mask(cap)) == 3'b000);
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] straps_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  sbe_pkg::sbe_state_t state_q;
  sbe_pkg::sbe_idx_t idx_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic [2:0] page_q;
  logic [10:0] addr_q;
  logic ack_drv_q;
  logic wrote_q;
  logic sda_oe_q;
  logic [7:0] devword_q;
  logic [31:0] twr_cnt_q;
  logic twr_done;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic byte_in;
  logic mem_we;
  logic [7:0] mem_q [0:2047];
  logic ctrl_en_q;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic standby_q;
  logic busy_q;

  // --------------------------------------------------------------------------
  // Pin synchronisation and line events
  // --------------------------------------------------------------------------
  sbe_sync #(
    .W(6)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i({scl_i, sda_i, wp_i, chip_select_straps}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign wp_s = pins_s[3];
  assign straps_s = pins_s[2:0];

  sbe_line_events u_events (
    .pclk(pclk),
    .presetn(presetn),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_ev(start_ev),
    .stop_ev(stop_ev)
  );

  // --------------------------------------------------------------------------
  // Datapath terms
  // --------------------------------------------------------------------------

  // Incoming bits are taken on the rising clock edge.
  assign rx_byte = {shift_q[6:0], sda_s};
  assign byte_in = scl_rise && (state_q == sbe_pkg::SBE_ST_RX) && (bitcnt_q == `SBE_LAST_BIT);
  assign rd_byte = mem_q[addr_q];
  // Protect pin high keeps every array location unchanged.
  assign mem_we = byte_in && (idx_q == sbe_pkg::SBE_IDX_DATA) && !wp_s;
  assign twr_done = (state_q == sbe_pkg::SBE_ST_PROG) && (twr_cnt_q == 32'(TWR_CYCLES - 1));

  // --------------------------------------------------------------------------
  // Link state machine
  // --------------------------------------------------------------------------

  // Start, stop and clock edges drive all transfers; the write cycle masks them all.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= sbe_pkg::SBE_ST_IDLE;
      idx_q <= sbe_pkg::SBE_IDX_DEV;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      page_q <= 3'b000;
      addr_q <= 11'h000;
      ack_drv_q <= 1'b0;
      wrote_q <= 1'b0;
      sda_oe_q <= 1'b0;
      devword_q <= 8'h00;
    end
    else if (state_q == sbe_pkg::SBE_ST_PROG)
    begin
      // Inputs are ignored, so polling gets no acknowledge until done.
      if (twr_done)
      begin
        state_q <= sbe_pkg::SBE_ST_IDLE;
        wrote_q <= 1'b0;
      end
    end
    else if (start_ev)
    begin
      // A start in any state but the write cycle drops the current byte and decodes a new address.
      state_q <= sbe_pkg::SBE_ST_RX;
      idx_q <= sbe_pkg::SBE_IDX_DEV;
      bitcnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      ack_drv_q <= 1'b0;
    end
    else if (stop_ev)
    begin
      // Stop releases the line; a pending write starts the timed cycle.
      sda_oe_q <= 1'b0;
      state_q <= wrote_q ? sbe_pkg::SBE_ST_PROG : sbe_pkg::SBE_ST_IDLE;
    end
    else
    begin
      case (state_q)
        sbe_pkg::SBE_ST_RX:
        begin
          if (scl_rise)
          begin
            shift_q <= rx_byte;
            bitcnt_q <= bitcnt_q + 4'h1;
            if (bitcnt_q == `SBE_LAST_BIT)
            begin
              ack_drv_q <= 1'b0;
              if (idx_q == sbe_pkg::SBE_IDX_DEV)
              begin
                if (ctrl_en_q && dev_match(rx_byte, straps_s, CAPACITY))
                begin
                  rw_q <= rx_byte[0];
                  page_q <= rx_byte[3:1] & ~strap_mask(CAPACITY);
                  devword_q <= rx_byte;
                  state_q <= sbe_pkg::SBE_ST_ACK;
                end
                else
                begin
                  state_q <= sbe_pkg::SBE_ST_IDLE;
                end
              end
              else if (idx_q == sbe_pkg::SBE_IDX_WADDR)
              begin
                // Page bits from the address word sit above the received byte.
                addr_q <= {page_q, rx_byte} & addr_mask(CAPACITY);
                state_q <= sbe_pkg::SBE_ST_ACK;
              end
              else
              begin
                // Writes roll over inside the current page.
                if (!wp_s)
                  wrote_q <= 1'b1;
                addr_q <= (addr_q & ~page_mask(CAPACITY)) |
                          ((addr_q + 11'h001) & page_mask(CAPACITY));
                state_q <= sbe_pkg::SBE_ST_ACK;
              end
            end
          end
        end
        sbe_pkg::SBE_ST_ACK:
        begin
          if (scl_fall)
          begin
            if (!ack_drv_q)
            begin
              // Pull low through the ninth clock.
              sda_oe_q <= 1'b1;
              ack_drv_q <= 1'b1;
            end
            else if (idx_q == sbe_pkg::SBE_IDX_DEV && rw_q)
            begin
              // First read bit goes out on the same falling edge.
              sda_oe_q <= ~rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
              bitcnt_q <= 4'h0;
              ack_drv_q <= 1'b0;
              state_q <= sbe_pkg::SBE_ST_TX;
            end
            else
            begin
              sda_oe_q <= 1'b0;
              bitcnt_q <= 4'h0;
              ack_drv_q <= 1'b0;
              idx_q <= (idx_q == sbe_pkg::SBE_IDX_DEV) ? sbe_pkg::SBE_IDX_WADDR :
                       sbe_pkg::SBE_IDX_DATA;
              state_q <= sbe_pkg::SBE_ST_RX;
            end
          end
        end
        sbe_pkg::SBE_ST_TX:
        begin
          if (scl_rise)
            bitcnt_q <= bitcnt_q + 4'h1;
          else if (scl_fall)
          begin
            if (bitcnt_q == `SBE_BYTE_DONE)
            begin
              // Release for the master's acknowledge; reads roll over the array.
              sda_oe_q <= 1'b0;
              addr_q <= (addr_q + 11'h001) & addr_mask(CAPACITY);
              state_q <= sbe_pkg::SBE_ST_MACK;
            end
            else
            begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        sbe_pkg::SBE_ST_MACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
              state_q <= sbe_pkg::SBE_ST_IDLE; // No acknowledge ends the read.
            else
              ack_drv_q <= 1'b1;
          end
          else if (scl_fall && ack_drv_q)
          begin
            sda_oe_q <= ~rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b0};
            bitcnt_q <= 4'h0;
            ack_drv_q <= 1'b0;
            state_q <= sbe_pkg::SBE_ST_TX;
          end
        end
        default:
        begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Array and write cycle timer
  // --------------------------------------------------------------------------

  // The array holds data only, so it carries no reset.
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem_q[addr_q] <= rx_byte;
  end

  // Counts the self-timed write cycle; long, so the length is a parameter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      twr_cnt_q <= 32'h00000000;
    else if (state_q != sbe_pkg::SBE_ST_PROG)
      twr_cnt_q <= 32'h00000000;
    else
      twr_cnt_q <= twr_cnt_q + 32'h00000001;
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------

  // Read decode; unmapped addresses answer with an error.
  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (paddr == `SBE_REG_CTRL)
      rd_mux[`SBE_CTRL_EN_BIT] = ctrl_en_q;
    else if (paddr == `SBE_REG_STATUS)
    begin
      rd_mux[`SBE_ST_STANDBY_BIT] = standby_q;
      rd_mux[`SBE_ST_BUSY_BIT] = busy_q;
      rd_mux[`SBE_ST_WP_BIT] = wp_s;
      rd_mux[`SBE_ST_RW_BIT] = rw_q;
    end
    else if (paddr == `SBE_REG_ADDR)
      rd_mux[10:0] = addr_q;
    else if (paddr == `SBE_REG_DEVWORD)
      rd_mux[7:0] = devword_q;
    else
      rd_err = 1'b1;
  end

  // One wait state: the answer is registered so every output leaves a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & rd_err;
      prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Control register; disabling makes the device ignore every address word.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_en_q <= `SBE_CTRL_RESET;
    else if (psel && penable && pready_q && pwrite && paddr == `SBE_REG_CTRL)
      ctrl_en_q <= pwdata[`SBE_CTRL_EN_BIT];
  end

  // Status outputs, one cycle behind the state machine.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      standby_q <= 1'b1;
      busy_q <= 1'b0;
    end
    else
    begin
      standby_q <= (state_q == sbe_pkg::SBE_ST_IDLE);
      busy_q <= (state_q == sbe_pkg::SBE_ST_PROG);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sda_oe = sda_oe_q;
  assign sda_o = 1'b0; // Open drain: the line is never driven high.
  assign standby_o = standby_q;
  assign busy_o = busy_q;

endmodule // sbe_front_end

/* verilog/sbe_line_events.sv */
// Clock edge and start/stop detection on the synchronised two-wire lines.
`timescale 1ns/1ps

module sbe_line_events (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Synchronised lines
  input wire logic scl_s,
  input wire logic sda_s,
  // One-cycle events
  output logic scl_rise,
  output logic scl_fall,
  output logic start_ev,
  output logic stop_ev
);

  logic scl_prev_q;
  logic sda_prev_q;

  // Previous line levels; idle bus is high on both wires.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // A data change while the clock stays high is a start or a stop, never a bit.
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

endmodule // sbe_line_events

/* verilog/sbe_sync.sv */
// Two-flop synchroniser for the pin inputs of the front end.
`timescale 1ns/1ps

module sbe_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous inputs and their synchronised copies
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage, never other logic.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '1;
      sync_o <= '1;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // sbe_sync
